// ==== src/pdpas_params.svh ====
// Constants for the port data, pull-up and analog select register block.
// Assumes inclusion by pdpas_pkg and by the design modules only.
`ifndef PDPAS_PARAMS_SVH
`define PDPAS_PARAMS_SVH

`define PDPAS_OFS_PORT2_DATA    16'hff02
`define PDPAS_OFS_PORT3_DATA    16'hff03
`define PDPAS_OFS_PORT4_DATA    16'hff04
`define PDPAS_OFS_PORT12_DATA   16'hff0c
`define PDPAS_OFS_PORT13_DATA   16'hff0d
`define PDPAS_OFS_PORT2_PULLUP  16'hff32
`define PDPAS_OFS_PORT3_PULLUP  16'hff33
`define PDPAS_OFS_PORT4_PULLUP  16'hff34
`define PDPAS_OFS_PORT12_PULLUP 16'hff3c
`define PDPAS_OFS_PORT2_ANALOG  16'hff84

`define PDPAS_MASK_PORT2_DATA    8'h0f
`define PDPAS_MASK_PORT3_DATA    8'h03
`define PDPAS_MASK_PORT3_READ    8'h13
`define PDPAS_BIT_PORT3_RESET_IN 4
`define PDPAS_MASK_PORT4_DATA    8'h3f
`define PDPAS_MASK_PORT12_DATA   8'h0e
`define PDPAS_MASK_PORT13_DATA   8'h01
`define PDPAS_MASK_PORT2_PULLUP  8'h0f
`define PDPAS_MASK_PORT3_PULLUP  8'h03
`define PDPAS_MASK_PORT4_PULLUP  8'h3f
`define PDPAS_MASK_PORT12_PULLUP 8'h08
`define PDPAS_BIT_PORT12_PULLUP  3
`define PDPAS_MASK_PORT2_ANALOG  8'h0f

`define PDPAS_RESET_VALUE        8'h00

`endif

// ==== src/pdpas_pkg.sv ====
// Types shared by the port register block.
// Assumes the constants header sits beside it in src/.
`include "pdpas_params.svh"
package pdpas_pkg;
  typedef logic [7:0]  pdpas_byte_t;
  typedef logic [15:0] pdpas_addr_t;
  typedef logic [2:0]  pdpas_bitsel_t;
endpackage : pdpas_pkg

// ==== src/pdpas_reg8.sv ====
// One 8-bit CPU register with a mask of implemented bits.
// Assumes the caller decodes the address into the two write strobes.
`include "pdpas_params.svh"
module pdpas_reg8
  import pdpas_pkg::*;
#(
  parameter pdpas_byte_t MASK = 8'hff
) (
  input  wire logic          core_clk,  // system clock
  input  wire logic          resetn,    // synchronous reset, active low
  input  wire logic          wr_byte,   // whole-byte write strobe
  input  wire logic          wr_bit,    // single-bit write strobe
  input  wire pdpas_bitsel_t bit_sel,   // bit index for wr_bit
  input  wire logic          bit_val,   // bit value for wr_bit
  input  wire pdpas_byte_t   wr_data,   // byte value for wr_byte
  output pdpas_byte_t        q          // stored value, unimplemented bits zero
);
  pdpas_byte_t q_r;
  pdpas_byte_t q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (wr_byte) begin
      q_nxt = wr_data & MASK; // RULE5 RULE15
    end else if (wr_bit) begin
      q_nxt[bit_sel] = bit_val; // RULE5
      q_nxt = q_nxt & MASK; // RULE15
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      q_r <= `PDPAS_RESET_VALUE; // RULE2 RULE7 RULE10
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule : pdpas_reg8

// ==== src/pdpas_top.sv ====
// Port data latches, pull-up enables and port-2 analog select, with pin drive.
// Assumes direction bits come from the neighbouring direction registers and
// that CPU strobes are one-cycle pulses synchronous to core_clk.
`include "pdpas_params.svh"
// Functional notes
// RULE1: Data read returns pin level for input bits, latch for output bits.
// RULE2: Reset clears every port output latch to zero.
// RULE3: Output latch 0/1 drives pin low/high; input low/high reads 0/1.
// RULE4: Port-3 bit 4 is read-only live reset-shared pin; writes ignored.
// RULE5: Data, analog and pull-up registers accept bit and byte writes.
// RULE6: Port-2 analog bit 1 selects converter input, 0 ordinary port.
// RULE7: Reset clears the port-2 analog select register.
// RULE8: Software keeps analog pins off digital use and clears their pull-ups.
// RULE9: Pull-up enable 1 connects the pull-up, 0 disconnects it.
// RULE10: Reset clears all four pull-up enable registers.
// RULE11: Pull-ups exist only on port-2 0-3, port-3 0-1, port-4 0-5, port-12 3.
// RULE12: Software sets direction and latch as each alternate function needs.
// RULE13: Direction 0 turns output buffer on, 1 makes pin an input.
// RULE14: Latch writes in input mode are kept but leave the pin alone.
// RULE15: Unimplemented bits read zero and ignore writes.
// RULE16: Analog mode forces port-2 driver and pull-up off.
module pdpas_top
  import pdpas_pkg::*;
(
  input  wire logic          core_clk,                   // system clock, 200 MHz
  input  wire logic          resetn,                     // synchronous reset, active low
  input  wire pdpas_addr_t   cpu_addr,                   // register address
  input  wire logic          cpu_wr,                     // byte write strobe
  input  wire logic          cpu_bit_wr,                 // single-bit write strobe
  input  wire pdpas_bitsel_t cpu_bit_sel,                // bit index for bit write
  input  wire logic          cpu_bit_val,                // bit value for bit write
  input  wire pdpas_byte_t   cpu_wdata,                  // byte write data
  input  wire logic          cpu_rd,                     // read strobe
  output pdpas_byte_t        cpu_rdata,                  // read data, one cycle after cpu_rd
  input  wire logic [3:0]    port2_pin_direction_bit,    // 1 input, 0 output
  input  wire logic [1:0]    port3_pin_direction_bit,    // 1 input, 0 output
  input  wire logic [5:0]    port4_pin_direction_bit,    // 1 input, 0 output
  input  wire logic [3:1]    port12_pin_direction_bit,   // 1 input, 0 output
  input  wire logic [3:0]    port2_pin_in,               // port-2 pin levels
  input  wire logic [1:0]    port3_pin_in,               // port-3 pin levels
  input  wire logic          reset_shared_input_bit,     // reset-shared input pin level
  input  wire logic [5:0]    port4_pin_in,               // port-4 pin levels
  input  wire logic [3:1]    port12_pin_in,              // port-12 pin levels
  output logic [3:0]         port2_pin_out,              // port-2 drive level
  output logic [3:0]         port2_pin_oe,               // port-2 driver enable, high drives
  output logic [1:0]         port3_pin_out,              // port-3 drive level
  output logic [1:0]         port3_pin_oe,               // port-3 driver enable
  output logic [5:0]         port4_pin_out,              // port-4 drive level
  output logic [5:0]         port4_pin_oe,               // port-4 driver enable
  output logic [3:1]         port12_pin_out,             // port-12 drive level
  output logic [3:1]         port12_pin_oe,              // port-12 driver enable
  output logic               port13_pin_out,             // output-only pin level
  output logic [3:0]         port2_pullup_on,            // port-2 pull-up connect
  output logic [1:0]         port3_pullup_on,            // port-3 pull-up connect
  output logic [5:0]         port4_pullup_on,            // port-4 pull-up connect
  output logic               port12_pullup_on,           // port-12 bit 3 pull-up connect
  output logic [3:0]         port2_analog_mode           // port-2 converter input select
);
  localparam int NREG = 10;
  localparam pdpas_addr_t ADDR [NREG] = '{
    `PDPAS_OFS_PORT2_DATA, `PDPAS_OFS_PORT3_DATA, `PDPAS_OFS_PORT4_DATA,
    `PDPAS_OFS_PORT12_DATA, `PDPAS_OFS_PORT13_DATA, `PDPAS_OFS_PORT2_PULLUP,
    `PDPAS_OFS_PORT3_PULLUP, `PDPAS_OFS_PORT4_PULLUP, `PDPAS_OFS_PORT12_PULLUP,
    `PDPAS_OFS_PORT2_ANALOG};
  localparam pdpas_byte_t MASK [NREG] = '{
    `PDPAS_MASK_PORT2_DATA, `PDPAS_MASK_PORT3_DATA, `PDPAS_MASK_PORT4_DATA,
    `PDPAS_MASK_PORT12_DATA, `PDPAS_MASK_PORT13_DATA, `PDPAS_MASK_PORT2_PULLUP,
    `PDPAS_MASK_PORT3_PULLUP, `PDPAS_MASK_PORT4_PULLUP, `PDPAS_MASK_PORT12_PULLUP,
    `PDPAS_MASK_PORT2_ANALOG};

  pdpas_byte_t q [NREG];
  pdpas_byte_t dir2;
  pdpas_byte_t dir3;
  pdpas_byte_t dir4;
  pdpas_byte_t dir12;
  pdpas_byte_t pin2;
  pdpas_byte_t pin3;
  pdpas_byte_t pin4;
  pdpas_byte_t pin12;
  logic [3:0]  analog;

  // Latch writes go through whatever the direction is; drive is gated separately.
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    pdpas_reg8 #(.MASK(MASK[i])) u_reg (
      .core_clk (core_clk),
      .resetn   (resetn),
      .wr_byte  (cpu_wr && (cpu_addr == ADDR[i])), // RULE14
      .wr_bit   (cpu_bit_wr && (cpu_addr == ADDR[i])),
      .bit_sel  (cpu_bit_sel),
      .bit_val  (cpu_bit_val),
      .wr_data  (cpu_wdata),
      .q        (q[i])
    );
  end

  assign dir2   = {4'h0, port2_pin_direction_bit};
  assign dir3   = {6'h00, port3_pin_direction_bit};
  assign dir4   = {2'h0, port4_pin_direction_bit};
  assign dir12  = {4'h0, port12_pin_direction_bit, 1'b0};
  assign pin2   = {4'h0, port2_pin_in};
  assign pin3   = {6'h00, port3_pin_in};
  assign pin4   = {2'h0, port4_pin_in};
  assign pin12  = {4'h0, port12_pin_in, 1'b0};
  assign analog = q[9][3:0]; // RULE6

  function automatic pdpas_byte_t mix(pdpas_byte_t latch, pdpas_byte_t dir,
                                      pdpas_byte_t pin);
    mix = (dir & pin) | (~dir & latch); // RULE1 RULE3
  endfunction : mix

  // Read path.
  pdpas_byte_t rdata_r;
  pdpas_byte_t rdata_nxt;
  pdpas_byte_t p3_rd;

  always_comb begin
    p3_rd = mix(q[1], dir3, pin3);
    p3_rd[`PDPAS_BIT_PORT3_RESET_IN] = reset_shared_input_bit; // RULE4
    rdata_nxt = rdata_r;
    if (cpu_rd) begin
      case (cpu_addr)
        `PDPAS_OFS_PORT2_DATA:    rdata_nxt = mix(q[0], dir2, pin2) & `PDPAS_MASK_PORT2_DATA;
        `PDPAS_OFS_PORT3_DATA:    rdata_nxt = p3_rd & `PDPAS_MASK_PORT3_READ; // RULE15
        `PDPAS_OFS_PORT4_DATA:    rdata_nxt = mix(q[2], dir4, pin4) & `PDPAS_MASK_PORT4_DATA;
        `PDPAS_OFS_PORT12_DATA:   rdata_nxt = mix(q[3], dir12, pin12) & `PDPAS_MASK_PORT12_DATA;
        `PDPAS_OFS_PORT13_DATA:   rdata_nxt = q[4];
        `PDPAS_OFS_PORT2_PULLUP:  rdata_nxt = q[5];
        `PDPAS_OFS_PORT3_PULLUP:  rdata_nxt = q[6];
        `PDPAS_OFS_PORT4_PULLUP:  rdata_nxt = q[7];
        `PDPAS_OFS_PORT12_PULLUP: rdata_nxt = q[8];
        `PDPAS_OFS_PORT2_ANALOG:  rdata_nxt = q[9];
        default:                  rdata_nxt = `PDPAS_RESET_VALUE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata_r <= `PDPAS_RESET_VALUE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign cpu_rdata = rdata_r;

  // Pin drive is registered so every pin output comes from a flop; the cost
  // is one cycle between a latch or direction change and the pin.
  logic [3:0] p2_out_r,  p2_out_nxt,  p2_oe_r,  p2_oe_nxt,  p2_pu_r,  p2_pu_nxt;
  logic [1:0] p3_out_r,  p3_out_nxt,  p3_oe_r,  p3_oe_nxt,  p3_pu_r,  p3_pu_nxt;
  logic [5:0] p4_out_r,  p4_out_nxt,  p4_oe_r,  p4_oe_nxt,  p4_pu_r,  p4_pu_nxt;
  logic [3:1] p12_out_r, p12_out_nxt, p12_oe_r, p12_oe_nxt;
  logic       p13_out_r, p13_out_nxt, p12_pu_r, p12_pu_nxt;
  logic [3:0] an_r,      an_nxt;

  always_comb begin
    p2_out_nxt  = q[0][3:0]; // RULE3
    p2_oe_nxt   = ~port2_pin_direction_bit & ~analog; // RULE13 RULE16
    p3_out_nxt  = q[1][1:0];
    p3_oe_nxt   = ~port3_pin_direction_bit; // RULE13
    p4_out_nxt  = q[2][5:0];
    p4_oe_nxt   = ~port4_pin_direction_bit; // RULE13
    p12_out_nxt = q[3][3:1];
    p12_oe_nxt  = ~port12_pin_direction_bit; // RULE13
    p13_out_nxt = q[4][0];
    p2_pu_nxt   = q[5][3:0] & ~analog; // RULE9 RULE11 RULE16
    p3_pu_nxt   = q[6][1:0]; // RULE9 RULE11
    p4_pu_nxt   = q[7][5:0]; // RULE9 RULE11
    p12_pu_nxt  = q[8][`PDPAS_BIT_PORT12_PULLUP]; // RULE9 RULE11
    an_nxt      = analog; // RULE6
  end

  // Directions reset to input elsewhere, so drivers start off here as well.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      p2_out_r  <= '0;
      p2_oe_r   <= '0;
      p2_pu_r   <= '0;
      p3_out_r  <= '0;
      p3_oe_r   <= '0;
      p3_pu_r   <= '0;
      p4_out_r  <= '0;
      p4_oe_r   <= '0;
      p4_pu_r   <= '0;
      p12_out_r <= '0;
      p12_oe_r  <= '0;
      p12_pu_r  <= 1'b0;
      p13_out_r <= 1'b0;
      an_r      <= '0;
    end else begin
      p2_out_r  <= p2_out_nxt;
      p2_oe_r   <= p2_oe_nxt;
      p2_pu_r   <= p2_pu_nxt;
      p3_out_r  <= p3_out_nxt;
      p3_oe_r   <= p3_oe_nxt;
      p3_pu_r   <= p3_pu_nxt;
      p4_out_r  <= p4_out_nxt;
      p4_oe_r   <= p4_oe_nxt;
      p4_pu_r   <= p4_pu_nxt;
      p12_out_r <= p12_out_nxt;
      p12_oe_r  <= p12_oe_nxt;
      p12_pu_r  <= p12_pu_nxt;
      p13_out_r <= p13_out_nxt;
      an_r      <= an_nxt;
    end
  end

  assign port2_pin_out     = p2_out_r;
  assign port2_pin_oe      = p2_oe_r;
  assign port3_pin_out     = p3_out_r;
  assign port3_pin_oe      = p3_oe_r;
  assign port4_pin_out     = p4_out_r;
  assign port4_pin_oe      = p4_oe_r;
  assign port12_pin_out    = p12_out_r;
  assign port12_pin_oe     = p12_oe_r;
  assign port13_pin_out    = p13_out_r;
  assign port2_pullup_on   = p2_pu_r;
  assign port3_pullup_on   = p3_pu_r;
  assign port4_pullup_on   = p4_pu_r;
  assign port12_pullup_on  = p12_pu_r;
  assign port2_analog_mode = an_r;
endmodule : pdpas_top

// ==== dv/pdpas_pin_model.sv ====
// Pin-side model of the board: each pin follows the block, an external driver or the pull-up.
// Assumes the testbench gives the external levels and enables.
module pdpas_pin_model #(parameter int W = 4) (
  input  wire logic [W-1:0] drv,      // block drive level
  input  wire logic [W-1:0] oe,       // block driver enable
  input  wire logic [W-1:0] pu,       // pull-up connected
  input  wire logic [W-1:0] xlv,      // external level
  input  wire logic [W-1:0] xen,      // external driver on
  input  wire logic         core_clk, // clock
  output logic      [W-1:0] lvl       // resulting pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  // An undriven pin without pull-up toggles so that no stale level can pass for a read.
  logic [W-1:0] flt_r = '0;
  always @(posedge core_clk) flt_r <= ~flt_r;
  assign lvl = (oe & drv) | (~oe & xen & xlv) | (~oe & ~xen & (pu | flt_r));
endmodule : pdpas_pin_model

// ==== dv/pdpas_properties.sv ====
// Timing checks on the port register block, bound to its top module.
// Assumes pin outputs lag register and direction changes by one cycle.
module pdpas_properties
  import pdpas_pkg::*;
(
  input wire logic        core_clk,                // clock
  input wire logic        resetn,                  // reset, active low
  input wire pdpas_addr_t cpu_addr,                // address
  input wire logic        cpu_wr,                  // byte write
  input wire pdpas_byte_t cpu_wdata,               // write data
  input wire logic        cpu_rd,                  // read
  input wire pdpas_byte_t cpu_rdata,               // read data
  input wire logic [3:0]  port2_pin_direction_bit, // direction
  input wire logic [1:0]  port3_pin_direction_bit, // direction
  input wire logic [5:0]  port4_pin_direction_bit, // direction
  input wire logic [3:0]  port2_pin_in,            // pin level
  input wire logic        reset_shared_input_bit,  // pin level
  input wire logic [3:0]  port2_pin_oe,            // enable
  input wire logic [1:0]  port3_pin_oe,            // enable
  input wire logic [5:0]  port4_pin_oe,            // enable
  input wire logic [3:0]  port2_pullup_on,         // pull-up
  input wire logic [3:0]  port2_analog_mode        // analog
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_an_wr;
    cpu_wr && cpu_addr == 16'hff84;
  endsequence
  sequence s_rd(a);
    cpu_rd && cpu_addr == a;
  endsequence
  property p_an;
    s_an_wr |-> ##2 {4'h0, port2_analog_mode} == ($past(cpu_wdata, 2) & 8'h0f);
  endproperty
  a_an: assert property (p_an) else $error("analog select copy wrong");
  property p_oe2;
    $past(resetn) |-> port2_pin_oe == (~$past(port2_pin_direction_bit) & ~port2_analog_mode);
  endproperty
  a_oe2: assert property (p_oe2) else $error("port2 enable wrong");
  property p_oe34;
    $past(resetn) |-> {port4_pin_oe, port3_pin_oe} ==
      ~{$past(port4_pin_direction_bit), $past(port3_pin_direction_bit)};
  endproperty
  a_oe34: assert property (p_oe34) else $error("port3 or port4 enable wrong");
  property p_pu2;
    (port2_pullup_on & port2_analog_mode) == 4'h0;
  endproperty
  a_pu2: assert property (p_pu2) else $error("pull-up on an analog pin");
  property p_unm;
    cpu_rd && !(cpu_addr inside {16'hff02, 16'hff03, 16'hff04, 16'hff0c, 16'hff0d,
      16'hff32, 16'hff33, 16'hff34, 16'hff3c, 16'hff84}) |=> cpu_rdata == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_hold;
    !cpu_rd |=> $stable(cpu_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_p3;
    s_rd(16'hff03) |=> cpu_rdata[4] == $past(reset_shared_input_bit)
      && (cpu_rdata & 8'hec) == 8'h00;
  endproperty
  a_p3: assert property (p_p3) else $error("port3 read wrong");
  property p_rd2;
    s_rd(16'hff02) |=> (cpu_rdata[3:0] & $past(port2_pin_direction_bit)) ==
      ($past(port2_pin_in) & $past(port2_pin_direction_bit)) && cpu_rdata[7:4] == 4'h0;
  endproperty
  a_rd2: assert property (p_rd2) else $error("port2 input read wrong");
endmodule : pdpas_properties

bind pdpas_top pdpas_properties pdpas_properties_inst (.core_clk, .resetn, .cpu_addr,
  .cpu_wr, .cpu_wdata, .cpu_rd, .cpu_rdata, .port2_pin_direction_bit,
  .port3_pin_direction_bit, .port4_pin_direction_bit, .port2_pin_in,
  .reset_shared_input_bit, .port2_pin_oe, .port3_pin_oe, .port4_pin_oe,
  .port2_pullup_on, .port2_analog_mode);

// ==== dv/pdpas_top_tb_top.sv ====
// Self-checking testbench for the port register block with pin models.
// Assumes one-cycle CPU strobes and registered read data.
module pdpas_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, resetn = 1'b0, cpu_wr = 1'b0, cpu_bit_wr = 1'b0, cpu_bit_val = 1'b0;
  logic cpu_rd = 1'b0, reset_shared_input_bit = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_wdata = 8'h00;
  logic [2:0] cpu_bit_sel = 3'h0;
  logic [3:0] port2_pin_direction_bit = 4'h0;
  logic [1:0] port3_pin_direction_bit = 2'h0;
  logic [5:0] port4_pin_direction_bit = 6'h00, x_lvl = 6'h00, x_en = 6'h3f, x4_en = 6'h3f;
  logic [3:1] port12_pin_direction_bit = 3'h0;
  wire [7:0] cpu_rdata;
  wire [3:0] port2_pin_in, port2_pin_out, port2_pin_oe, port2_pullup_on, port2_analog_mode;
  wire [1:0] port3_pin_in, port3_pin_out, port3_pin_oe, port3_pullup_on;
  wire [5:0] port4_pin_in, port4_pin_out, port4_pin_oe, port4_pullup_on;
  wire [3:1] port12_pin_in, port12_pin_out, port12_pin_oe;
  wire       port13_pin_out, port12_pullup_on;
  int n_fail = 0, checks = 0;
  logic [15:0] ofs [10] = '{16'hff02, 16'hff03, 16'hff04, 16'hff0c, 16'hff0d,
                            16'hff32, 16'hff33, 16'hff34, 16'hff3c, 16'hff84};
  logic [7:0] msk [10] = '{8'h0f, 8'h03, 8'h3f, 8'h0e, 8'h01, 8'h0f, 8'h03, 8'h3f, 8'h08, 8'h0f};

  pdpas_top pdpas_top_inst (.core_clk, .resetn, .cpu_addr, .cpu_wr, .cpu_bit_wr, .cpu_bit_sel,
    .cpu_bit_val, .cpu_wdata, .cpu_rd, .cpu_rdata, .port2_pin_direction_bit,
    .port3_pin_direction_bit, .port4_pin_direction_bit, .port12_pin_direction_bit,
    .port2_pin_in, .port3_pin_in, .reset_shared_input_bit, .port4_pin_in, .port12_pin_in,
    .port2_pin_out, .port2_pin_oe, .port3_pin_out, .port3_pin_oe, .port4_pin_out,
    .port4_pin_oe, .port12_pin_out, .port12_pin_oe, .port13_pin_out, .port2_pullup_on,
    .port3_pullup_on, .port4_pullup_on, .port12_pullup_on, .port2_analog_mode);
  pdpas_pin_model #(.W(4)) p2_model (.core_clk, .drv(port2_pin_out), .oe(port2_pin_oe),
    .pu(port2_pullup_on), .xlv(x_lvl[3:0]), .xen(x_en[3:0]), .lvl(port2_pin_in));
  pdpas_pin_model #(.W(2)) p3_model (.core_clk, .drv(port3_pin_out), .oe(port3_pin_oe),
    .pu(port3_pullup_on), .xlv(x_lvl[1:0]), .xen(x_en[1:0]), .lvl(port3_pin_in));
  pdpas_pin_model #(.W(6)) p4_model (.core_clk, .drv(port4_pin_out), .oe(port4_pin_oe),
    .pu(port4_pullup_on), .xlv(x_lvl), .xen(x4_en), .lvl(port4_pin_in));
  pdpas_pin_model #(.W(3)) p12_model (.core_clk, .drv(port12_pin_out), .oe(port12_pin_oe),
    .pu({port12_pullup_on, 2'b00}), .xlv(x_lvl[3:1]), .xen(x_en[3:1]), .lvl(port12_pin_in));

  always #2.5 core_clk = ~core_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge core_clk);
    cpu_wr <= 1'b0;
  endtask : wr
  task automatic bw(input logic [15:0] a, input logic [2:0] b, input logic v);
    @(posedge core_clk);
    cpu_addr <= a;
    cpu_bit_sel <= b;
    cpu_bit_val <= v;
    cpu_bit_wr <= 1'b1;
    @(posedge core_clk);
    cpu_bit_wr <= 1'b0;
  endtask : bw
  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge core_clk);
    cpu_rd <= 1'b0;
    #1 chk(cpu_rdata, e);
  endtask : rc
  // All port pins are outputs here, so data reads show the latches; port-3 bit 4 still shows the reset-shared pin, held low.
  task automatic t_reset;
    @(posedge core_clk);
    resetn <= 1'b0;
    {port2_pin_direction_bit, port3_pin_direction_bit, port12_pin_direction_bit} <= 9'h000;
    port4_pin_direction_bit <= 6'h00;
    reset_shared_input_bit <= 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    chk({port2_pullup_on, port2_analog_mode}, 8'h00);
    for (int i = 0; i < 10; i++)
      rc(ofs[i], 8'h00);
  endtask : t_reset
  task automatic t_byte;
    for (int i = 0; i < 10; i++) begin
      wr(ofs[i], 8'hff);
      rc(ofs[i], msk[i]);
    end
    @(posedge core_clk);
    #1 chk({port4_pin_out, port3_pin_out}, 8'hff);
    chk({port4_pin_oe, port3_pin_oe}, 8'hff);
    chk({port2_pin_oe, port2_pullup_on}, 8'h00);
    chk({port12_pin_out, port13_pin_out, port12_pullup_on, port12_pin_oe}, 8'hff);
    chk({port4_pullup_on, port3_pullup_on}, 8'hff);
    for (int b = 0; b < 4; b++)
      bw(16'hff84, b[2:0], 1'b0);
    rc(16'hff84, 8'h00);
    chk({port2_pin_oe, port2_pullup_on}, 8'hff);
    chk({port2_pin_out, port2_pin_oe}, 8'hff);
    bw(16'hff02, 3'h7, 1'b1);
    bw(16'hff02, 3'h0, 1'b0);
    rc(16'hff02, 8'h0e);
    wr(16'hff05, 8'h55);
    rc(16'hff05, 8'h00);
    // Software drops the pull-up before it hands pin 1 to the converter.
    bw(16'hff32, 3'h1, 1'b0);
    bw(16'hff84, 3'h1, 1'b1);
    rc(16'hff84, 8'h02);
    chk({4'h0, port2_analog_mode}, 8'h02);
    chk({port2_pin_oe, port2_pullup_on}, 8'hdd);
  endtask : t_byte
  task automatic t_input;
    @(posedge core_clk);
    {port2_pin_direction_bit, port3_pin_direction_bit, port12_pin_direction_bit} <= 9'h1ff;
    port4_pin_direction_bit <= 6'h3f;
    x_lvl <= 6'h15;
    reset_shared_input_bit <= 1'b1;
    wr(16'hff04, 8'h2a);
    rc(16'hff04, 8'h15);
    chk({2'b00, port4_pin_oe}, 8'h00);
    rc(16'hff02, 8'h05);
    rc(16'hff03, 8'h11);
    rc(16'hff0c, 8'h04);
    @(posedge core_clk);
    x4_en <= 6'h00;
    rc(16'hff04, 8'h3f);
    @(posedge core_clk);
    reset_shared_input_bit <= 1'b0;
    wr(16'hff03, 8'h10);
    rc(16'hff03, 8'h01);
    @(posedge core_clk);
    port4_pin_direction_bit <= 6'h00;
    rc(16'hff04, 8'h2a);
    chk({2'b00, port4_pin_out}, 8'h2a);
    // Bit 3 as transmit output wants latch 1, bit 2 as timer output latch 0.
    chk({2'b00, port4_pin_in}, 8'h2a);
  endtask : t_input
  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    t_reset();
    t_byte();
    t_input();
    t_reset();
    end_of_test();
  end
  // The tests need well under a thousand cycles; this bound only catches a hang.
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    end_of_test();
  end
endmodule : pdpas_top_tb_top
